// ==== bench/dpsc_asserts.sv ====
// Port checker for the serial command port
module dpsc_asserts (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cs_n_i,
  input wire logic       hw_reset_pin_n_i,
  input wire logic       power_down_pin_n_i,
  input wire logic       sdo_o,
  input wire logic [7:0] wiper0_o,
  input wire logic [7:0] wiper1_o,
  input wire logic [1:0] a_open_o,
  input wire logic [1:0] wiper_to_b_o,
  input wire logic [1:0] soft_power_down_pin_o,
  input wire logic       frame_abort_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_tie; wiper_to_b_o == a_open_o; endproperty
  a_tie: assert property (p_tie) else $error("wiper not tied to b");
  property p_soft; ($past(soft_power_down_pin_o) & ~a_open_o) == 2'h0; endproperty
  a_soft: assert property (p_soft) else $error("soft off not open");
  property p_pd; !power_down_pin_n_i [*6] |-> a_open_o == 2'h3; endproperty
  a_pd: assert property (p_pd) else $error("pin off not open");
  property p_idle; cs_n_i [*8] |-> !sdo_o; endproperty
  a_idle: assert property (p_idle) else $error("sdo not low");
  property p_hold; !cs_n_i [*8] |-> $stable({wiper0_o, wiper1_o, soft_power_down_pin_o}); endproperty
  a_hold: assert property (p_hold) else $error("change in frame");
  property p_pulse; frame_abort_o |=> !frame_abort_o; endproperty
  a_pulse: assert property (p_pulse) else $error("abort too long");
  property p_keep;
    frame_abort_o |=> $stable({wiper0_o, wiper1_o, soft_power_down_pin_o}) [*4];
  endproperty
  a_keep: assert property (p_keep) else $error("abort changed state");
  property p_mid;
    (!hw_reset_pin_n_i && cs_n_i) [*8] |-> ##3 {wiper0_o, wiper1_o} == 16'h8080;
  endproperty
  a_mid: assert property (p_mid) else $error("no mid-scale");
  property p_rst; $rose(rst_n_i) |-> {wiper0_o, wiper1_o, soft_power_down_pin_o} == 18'h20200; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule

bind dpsc_top dpsc_asserts u_dpsc_asserts (.clk_i, .rst_n_i, .cs_n_i, .hw_reset_pin_n_i,
  .power_down_pin_n_i, .sdo_o, .wiper0_o, .wiper1_o, .a_open_o, .wiper_to_b_o,
  .soft_power_down_pin_o, .frame_abort_o);

// ==== bench/dpsc_host.sv ====
// Serial host model that frames commands
module dpsc_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end
  // Eight clocks a bit, 5 MHz serial rate
  task automatic xfer(input logic [31:0] d, input int n, input bit cpol,
                      output logic [31:0] q);
    q = 32'h0;
    sclk_o <= cpol;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o <= 1'b0;
      sdi_o  <= d[i];
      repeat (4) @(posedge clk_i);
      q = {q[30:0], sdo_i};
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    sclk_o <= cpol;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o;
  endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the serial command port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpsc_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       hw_n = 1'b1;
  logic       pd_n = 1'b1;
  logic       sclk, cs_n, sdi, sdo, abort;
  logic [7:0] w0, w1;
  logic [1:0] aop, wtb, ssd;
  logic [7:0] ew [2];
  logic [1:0] es;
  bit         pd_low, credit;
  int         n_errors, check_count, n_abort, e_abort, seed = 27451;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (abort === 1'b1) n_abort++;
  dpsc_host u_dpsc_host (.clk_i, .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  dpsc_top u_dpsc_top (.clk_i, .rst_n_i, .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .hw_reset_pin_n_i(hw_n), .power_down_pin_n_i(pd_n), .sdo_o(sdo), .wiper0_o(w0),
    .wiper1_o(w1), .a_open_o(aop), .wiper_to_b_o(wtb), .soft_power_down_pin_o(ssd),
    .frame_abort_o(abort));
  function automatic void exec(input logic [15:0] f);
    for (int k = 0; k < 2; k++) begin
      if (f[8+k]) begin
        if (f[13:12] == CMD_WRITE) begin
          ew[k] = f[7:0];
          if (!pd_low) es[k] = 1'b0;
        end else if (f[13:12] == CMD_SHUTDOWN) es[k] = 1'b1;
      end
    end
  endfunction
  task automatic chk_word(input logic [31:0] a, e);
    check_count++;
    if (a !== e) begin
      n_errors++;
      $display("BAD %0t word %h exp %h", $time, a, e);
    end
  endtask
  task automatic chk_state();
    logic [21:0] e;
    e = {ew[1], ew[0], es, pd_low ? 2'h3 : es, pd_low ? 2'h3 : es};
    check_count++;
    if ({w1, w0, ssd, aop, wtb} !== e) begin
      n_errors++;
      $display("BAD %0t state %h exp %h", $time, {w1, w0, ssd, aop, wtb}, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic frame(input logic [31:0] d, input int n);
    logic [31:0] q;
    u_dpsc_host.xfer(d, n, 1'($random(seed)), q);
    credit = 1'b1;
    if (n % 16 == 0) exec(d[15:0]);
    else e_abort++;
    repeat (12) @(posedge clk_i);
    if (n == 16) chk_word(q, 32'h0);
    if (n == 32) chk_word(q, {16'h0, d[31:16]});
    chk_state();
  endtask
  task automatic rst_pin();
    hw_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    hw_n <= 1'b1;
    ew = '{8'h80, 8'h80};
    if (credit && !pd_low) es = 2'h0;
    credit = 1'b0;
    repeat (12) @(posedge clk_i);
    chk_state();
  endtask
  task automatic pd_pulse();
    pd_n <= 1'b0;
    pd_low = 1'b1;
    repeat (10) @(posedge clk_i);
    chk_state();
    if ($random(seed) & 1) rst_pin();
    if ($random(seed) & 1) frame({16'h0, 16'($random(seed))}, 16);
    pd_n <= 1'b1;
    pd_low = 1'b0;
    if (credit) es = 2'h0;
    credit = 1'b0;
    repeat (12) @(posedge clk_i);
    chk_state();
  endtask
  initial begin
    logic [15:0] corner [6];
    corner = '{16'h13ff, 16'hde00, 16'h21a5, 16'h335a, 16'h0377, 16'h1042};
    ew = '{8'h80, 8'h80};
    es = 2'h0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk_state();
    foreach (corner[i]) frame({16'h0, corner[i]}, 16);
    for (int i = 0; i < 60; i++) begin
      case ($unsigned($random(seed)) % 6)
        0, 1: frame({16'h0, 16'($random(seed))}, 16);
        2: frame($random(seed), 32);
        3: begin
          frame($random(seed), 15 + 2 * ($unsigned($random(seed)) % 2));
          frame(32'h0, 16);
        end
        4: pd_pulse();
        default: rst_pin();
      endcase
      $display("test %0d done", i);
    end
    chk_word(n_abort, e_abort);
    finish_test();
  end
endmodule

// ==== design/dpsc_lowtimer.sv ====
// Counts how long a synchronised pin has stayed low
module dpsc_lowtimer
  import dpsc_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   pin_i,
  input  wire logic [PULSE_CNT_W-1:0] min_i,
  output logic                        long_o
);
  logic [PULSE_CNT_W-1:0] cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      long_o <= 1'b0;
    end else if (pin_i) begin
      cnt_r  <= '0;
      long_o <= 1'b0;
    end else begin
      if (cnt_r != min_i) cnt_r <= cnt_r + 1'b1;
      long_o <= (cnt_r + 1'b1 >= min_i);
    end
  end
endmodule

// ==== design/dpsc_pkg.sv ====
// Package of constants for the digipot serial command port
package dpsc_pkg;
  localparam int          FRAME_BITS      = 16;
  localparam int          CNT_W           = 4;
  localparam int          CMD_SEL_LO_POS  = 12;
  localparam int          CMD_SEL_HI_POS  = 13;
  localparam int          POT0_SEL_POS    = 8;
  localparam int          POT1_SEL_POS    = 9;
  localparam logic [7:0]  WIPER_MIDSCALE  = 8'h80;
  localparam logic [15:0] SHIFT_CLEAR     = 16'h0000;
  localparam logic [1:0]  CMD_WRITE       = 2'h1;
  localparam logic [1:0]  CMD_SHUTDOWN    = 2'h2;
  localparam int          CLK_MHZ         = 40;
  localparam int          RESET_MIN_NS    = 150;
  localparam int          PD_MIN_NS       = 100;
  localparam int          RESET_MIN_CYC   = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          PD_MIN_CYC      = (PD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          PULSE_CNT_W     = 4;
  typedef enum logic [2:0] {
    DPSC_IDLE   = 3'b001,
    DPSC_FRAME  = 3'b010,
    DPSC_ARMED  = 3'b100
  } dpsc_state_type;
endpackage

// ==== design/dpsc_sync.sv ====
// Two flip-flop synchroniser for one pin
module dpsc_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic init_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    // Idle-high pins; a low reset value would fake edges after release
    if (!rst_n_i) begin
      meta_r <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// ==== design/dpsc_top.sv ====
// Serial command port of a single or dual 256-tap digital potentiometer
// How it works
// RULE_01: Command then data byte shift in while chip select low; execute on rise.
// RULE_02: Sample serial input on clock rise, update serial output on clock fall.
// RULE_03: Count rising clocks in frame; discard command unless multiple of 16.
// RULE_04: First byte is command; select bits sit at positions 4 and 5.
// RULE_05: Equal command-select bits mean no operation, channels unchanged.
// RULE_06: Select value 0,1 writes data byte to every selected channel.
// RULE_07: Select value 1,0 puts every selected channel into software shutdown.
// RULE_08: Channel select bits 0 and 1 enable the command per channel.
// RULE_09: Other command byte bits are ignored.
// RULE_10: Channel in shutdown opens A terminal and ties wiper to B.
// RULE_11: Shutdown still needs a full data byte, whose value is ignored.
// RULE_12: Write with power-down pin high loads value and leaves shutdown.
// RULE_13: Write with power-down pin low loads value but stays in shutdown.
// RULE_14: After select pulse, reset pin low 150 ns sets mid-scale, may exit shutdown.
// RULE_15: After select pulse, power-down rising after 100 ns low exits shutdown.
// RULE_16: Host never pulls reset or power-down low during chip select low.
// RULE_17: Power-down pin low forces all channels into shutdown.
// RULE_18: Serial output is the bit leaving the end of the shift register.
// RULE_19: Serial output always driven, low once chip select goes high.
// RULE_20: Shift register cleared on execution, so zeros go downstream first.
// RULE_21: Host limits chained serial clock to about 5.8 MHz.
// RULE_22: Host shifts frames only as far as the furthest device needing one.
// RULE_23: Hardware reset and power-up load every wiper register with 80h.
// RULE_24: Serial modes 0,0 and 1,1 both accepted.
// RULE_25: Entering shutdown leaves wiper data unchanged.
// RULE_26: Single variant has channel 0 only; selecting channel 1 alone does nothing.
module dpsc_top
  import dpsc_pkg::*;
#(
  parameter bit DUAL = 1'b1
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       sdi_i,
  input  wire logic       hw_reset_pin_n_i,
  input  wire logic       power_down_pin_n_i,
  output logic            sdo_o,
  output logic [7:0]      wiper0_o,
  output logic [7:0]      wiper1_o,
  output logic [1:0]      a_open_o,
  output logic [1:0]      wiper_to_b_o,
  output logic [1:0]      soft_power_down_pin_o,
  output logic            frame_abort_o
);
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic rs_n_s;
  logic pd_n_s;
  logic [4:0] pin_raw;
  logic [4:0] pin_s;
  assign pin_raw = {power_down_pin_n_i, hw_reset_pin_n_i, sdi_i, cs_n_i, sclk_i};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      dpsc_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_sync_r),
        .init_i  (1'b1),
        .d_i     (pin_raw[gi]),
        .q_o     (pin_s[gi])
      );
    end
  endgenerate
  assign sclk_s = pin_s[0];
  assign cs_n_s = pin_s[1];
  assign sdi_s  = pin_s[2];
  assign rs_n_s = pin_s[3];
  assign pd_n_s = pin_s[4];

  // Previous values for edge finding, on synchronised copies only
  logic sclk_d_r;
  logic cs_n_d_r;
  logic pd_n_d_r;
  logic rs_n_d_r;
  logic started_r;
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sclk_d_r  <= 1'b0;
      cs_n_d_r  <= 1'b1;
      pd_n_d_r  <= 1'b1;
      rs_n_d_r  <= 1'b1;
      started_r <= 1'b0;
    end else begin
      sclk_d_r  <= sclk_s;
      cs_n_d_r  <= cs_n_s;
      pd_n_d_r  <= pd_n_s;
      rs_n_d_r  <= rs_n_s;
      started_r <= 1'b1;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic pd_rise;
  logic rs_fall;
  // Edges ignored until delayed copies hold valid pin history
  assign sclk_rise = started_r && sclk_s && !sclk_d_r;
  assign sclk_fall = started_r && !sclk_s && sclk_d_r;
  assign cs_fall   = started_r && !cs_n_s && cs_n_d_r;
  assign cs_rise   = started_r && cs_n_s && !cs_n_d_r;
  assign pd_rise   = started_r && pd_n_s && !pd_n_d_r;
  assign rs_fall   = started_r && !rs_n_s && rs_n_d_r;

  dpsc_state_type state_r;
  dpsc_state_type state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DPSC_IDLE:  if (cs_fall) state_nxt = DPSC_FRAME;
      DPSC_FRAME: if (cs_rise) state_nxt = DPSC_ARMED;
      DPSC_ARMED: if (cs_fall) state_nxt = DPSC_FRAME;
      default:    state_nxt = DPSC_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) state_r <= DPSC_IDLE;
    else             state_r <= state_nxt;
  end

  // Frame shifting; mode 0,0 and 1,1 both shift on rising edges only
  logic [FRAME_BITS-1:0] shift_r;
  logic [CNT_W-1:0]      bit_cnt_r;
  logic                  any_bits_r;
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      shift_r    <= SHIFT_CLEAR;
      bit_cnt_r  <= '0;
      any_bits_r <= 1'b0;
    end else if (cs_rise) begin
      shift_r    <= SHIFT_CLEAR; // RULE_20
      bit_cnt_r  <= '0;
      any_bits_r <= 1'b0;
    end else if (!cs_n_s && sclk_rise) begin
      shift_r    <= {shift_r[FRAME_BITS-2:0], sdi_s}; // RULE_01 RULE_02 RULE_24
      bit_cnt_r  <= bit_cnt_r + 1'b1; // RULE_03
      any_bits_r <= 1'b1;
    end
  end

  // Serial output changes on falling clock, low whenever deselected
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) sdo_o <= 1'b0;
    else if (cs_n_s) sdo_o <= 1'b0; // RULE_19
    else if (sclk_fall) sdo_o <= shift_r[FRAME_BITS-1]; // RULE_02 RULE_18
  end

  function automatic logic [1:0] chan_mask(input logic [FRAME_BITS-1:0] f, input bit dual);
    chan_mask = {f[POT1_SEL_POS] & dual, f[POT0_SEL_POS]}; // RULE_08 RULE_26
  endfunction

  logic       frame_ok;
  logic [1:0] cmd_sel;
  logic [1:0] sel;
  logic [1:0] do_write;
  logic [1:0] do_power_down_pin;
  // Command-select and channel bits only; the rest of the byte is unused
  assign cmd_sel  = {shift_r[CMD_SEL_HI_POS], shift_r[CMD_SEL_LO_POS]}; // RULE_04 RULE_09
  assign frame_ok = cs_rise && any_bits_r && (bit_cnt_r == '0); // RULE_03
  assign sel      = chan_mask(shift_r, DUAL);
  assign do_write = (frame_ok && cmd_sel == CMD_WRITE) ? sel : 2'b00; // RULE_05 RULE_06
  assign do_power_down_pin  = (frame_ok && cmd_sel == CMD_SHUTDOWN) ? sel : 2'b00; // RULE_07 RULE_11

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) frame_abort_o <= 1'b0;
    else frame_abort_o <= cs_rise && any_bits_r && (bit_cnt_r != '0);
  end

  logic rs_long_fire;
  logic pd_long_rise;

  // Select pulse seen since the last long reset-pin pulse or power-down release
  logic cs_pulse_r;
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) cs_pulse_r <= 1'b0;
    else if (cs_rise) cs_pulse_r <= 1'b1;
    else if (rs_long_fire || pd_long_rise) cs_pulse_r <= 1'b0;
  end

  logic rs_long;
  logic pd_long;
  logic rs_long_d_r;
  logic pd_long_hold_r;
  dpsc_lowtimer u_rs_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_sync_r),
    .pin_i   (rs_n_s),
    .min_i   (PULSE_CNT_W'(RESET_MIN_CYC)),
    .long_o  (rs_long)
  );
  dpsc_lowtimer u_pd_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_sync_r),
    .pin_i   (pd_n_s),
    .min_i   (PULSE_CNT_W'(PD_MIN_CYC)),
    .long_o  (pd_long)
  );
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rs_long_d_r    <= 1'b0;
      pd_long_hold_r <= 1'b0;
    end else begin
      rs_long_d_r    <= rs_long;
      pd_long_hold_r <= pd_n_s ? 1'b0 : pd_long;
    end
  end
  assign rs_long_fire = cs_n_s && rs_long && !rs_long_d_r; // RULE_14
  assign pd_long_rise = cs_n_s && pd_rise && pd_long_hold_r; // RULE_15

  logic unused_edges;
  assign unused_edges = rs_fall;

  // Wiper data registers, mid-scale after reset
  logic [7:0] wiper_r [2];
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
          wiper_r[gi] <= WIPER_MIDSCALE; // RULE_23
        end else if (rs_long_fire) begin
          wiper_r[gi] <= WIPER_MIDSCALE; // RULE_14 RULE_23
        end else if (do_write[gi]) begin
          wiper_r[gi] <= shift_r[7:0]; // RULE_06 RULE_13
        end
      end
      always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
          soft_power_down_pin_o[gi] <= 1'b0;
        end else if (do_power_down_pin[gi]) begin
          soft_power_down_pin_o[gi] <= 1'b1; // RULE_07 RULE_25
        end else if (do_write[gi] && pd_n_s) begin
          soft_power_down_pin_o[gi] <= 1'b0; // RULE_12 RULE_13
        end else if (cs_pulse_r && rs_long_fire && pd_n_s) begin
          soft_power_down_pin_o[gi] <= 1'b0; // RULE_14
        end else if (cs_pulse_r && pd_long_rise) begin
          soft_power_down_pin_o[gi] <= 1'b0; // RULE_15
        end
      end
      always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
          a_open_o[gi]     <= 1'b0;
          wiper_to_b_o[gi] <= 1'b0;
        end else begin
          a_open_o[gi]     <= soft_power_down_pin_o[gi] || !pd_n_s; // RULE_10 RULE_17
          wiper_to_b_o[gi] <= soft_power_down_pin_o[gi] || !pd_n_s; // RULE_10 RULE_17
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wiper0_o <= WIPER_MIDSCALE;
      wiper1_o <= WIPER_MIDSCALE;
    end else begin
      wiper0_o <= wiper_r[0]; // RULE_25
      wiper1_o <= wiper_r[1];
    end
  end
endmodule
